/* rtl/iofs_consts.svh */
// Parameter numbers, I/O references, field positions and sizes of the bank
`ifndef IOFS_CONSTS_SVH
`define IOFS_CONSTS_SVH

// Parameter numbers reached by the parameter instructions
`define IOFS_PN_FP_OUT_VAL 16'h083d
`define IOFS_PN_RMT_OUT_VAL 16'h083e
`define IOFS_PN_RMT_FAULT 16'h0841
`define IOFS_PN_FP_SRC 16'h0842
`define IOFS_PN_RMT_SRC 16'h0843
`define IOFS_PN_HIST_FIRST 16'h09c4
`define IOFS_PN_HIST_LAST 16'h09cd

// Digital I/O reference points reached by the I/O instructions
`define IOFS_REF_FP_IN_FIRST 16'h0bb8
`define IOFS_REF_FP_IN_LAST 16'h0bbf
`define IOFS_REF_RMT_IN_FIRST 16'h0bd8
`define IOFS_REF_RMT_IN_LAST 16'h0be7
`define IOFS_REF_FP_OUT_FIRST 16'h0c38
`define IOFS_REF_FP_OUT_LAST 16'h0c39
`define IOFS_REF_RMT_OUT_FIRST 16'h0c58
`define IOFS_REF_RMT_OUT_LAST 16'h0c63
// Whole span of I/O references, never reachable as parameters
`define IOFS_REF_SPAN_FIRST 16'h0bb8
`define IOFS_REF_SPAN_LAST 16'h0c63

// Fault status word field positions
`define IOFS_FLT_OT_LSB 0
`define IOFS_FLT_OL_LSB 16
`define IOFS_FLT_PWR_T1 30
`define IOFS_FLT_PWR_T2 31

// Sizes
`define IOFS_FP_OUTS 2
`define IOFS_RMT_OUTS 12
`define IOFS_FLT_OUTS 8
`define IOFS_FP_INS 8
`define IOFS_RMT_INS 16
`define IOFS_HIST_DEPTH 10

// Reset values
`define IOFS_SRC_RESET 32'h0000_0000
`define IOFS_VAL_RESET 32'h0000_0000

`endif

/* rtl/iofs_pkg.sv */
// Types shared by the output fault, source select and event bank
package iofs_pkg;

  // Instruction kinds arriving on the command port
  typedef enum logic [1:0] {
    IOFS_CMD_PARAM_RD = 2'h0,
    IOFS_CMD_PARAM_WR = 2'h1,
    IOFS_CMD_IO_RD = 2'h2,
    IOFS_CMD_IO_WR = 2'h3
  } iofs_cmd_t;

  // Command sequencer states, Gray coded
  typedef enum logic [1:0] {
    IOFS_ST_IDLE = 2'b00,
    IOFS_ST_BUSY = 2'b01
  } iofs_state_t;

endpackage : iofs_pkg

/* rtl/iofs_event_mem.sv */
// Ten-word event history, newest in word 0, registered read port
`timescale 1ns/1ps
`include "iofs_consts.svh"

module iofs_event_mem (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Push side
  input wire logic push,
  input wire logic [31:0] push_data,
  // Read side
  input wire logic [3:0] rd_index,
  output logic [31:0] rd_data_q
);

  logic [31:0] word_q [`IOFS_HIST_DEPTH];

  // Each push moves every entry one place older; the oldest falls off
  genvar gi;
  generate
    for (gi = 0; gi < `IOFS_HIST_DEPTH; gi++) begin : g_slot
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          word_q[gi] <= 32'h0000_0000;
        end else if (push) begin
          if (gi == 0) begin
            word_q[gi] <= push_data;
          end else begin
            word_q[gi] <= word_q[(gi > 0) ? gi - 1 : 0];
          end
        end
      end
    end
  endgenerate

  // Registered read; out-of-range index reads zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= 32'h0000_0000;
    end else if (rd_index < 4'(`IOFS_HIST_DEPTH)) begin
      rd_data_q <= word_q[rd_index];
    end else begin
      rd_data_q <= 32'h0000_0000;
    end
  end

endmodule : iofs_event_mem

/* rtl/iofs_point_map.sv */
// Decodes a digital I/O reference and returns the single point value
`timescale 1ns/1ps
`include "iofs_consts.svh"

module iofs_point_map (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Reference to look up
  input wire logic [15:0] ref_num,
  // Point values
  input wire logic [`IOFS_FP_INS-1:0] fp_in,
  input wire logic [`IOFS_RMT_INS-1:0] rmt_in,
  input wire logic [`IOFS_FP_OUTS-1:0] fp_out_val,
  input wire logic [`IOFS_RMT_OUTS-1:0] rmt_out_val,
  // Registered result
  output logic hit_q,
  output logic is_input_q,
  output logic bit_q
);

  logic [15:0] fp_in_off;
  logic [15:0] rmt_in_off;
  logic [15:0] fp_out_off;
  logic [15:0] rmt_out_off;

  // Offsets into each point group
  assign fp_in_off = ref_num - `IOFS_REF_FP_IN_FIRST;
  assign rmt_in_off = ref_num - `IOFS_REF_RMT_IN_FIRST;
  assign fp_out_off = ref_num - `IOFS_REF_FP_OUT_FIRST;
  assign rmt_out_off = ref_num - `IOFS_REF_RMT_OUT_FIRST;

  // One lookup per cycle; the result is valid the cycle after
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hit_q <= 1'b0;
      is_input_q <= 1'b0;
      bit_q <= 1'b0;
    end else if (ref_num >= `IOFS_REF_FP_IN_FIRST &&
                 ref_num <= `IOFS_REF_FP_IN_LAST) begin
      hit_q <= 1'b1; // R14 R15
      is_input_q <= 1'b1;
      bit_q <= fp_in[fp_in_off[2:0]];
    end else if (ref_num >= `IOFS_REF_RMT_IN_FIRST &&
                 ref_num <= `IOFS_REF_RMT_IN_LAST) begin
      hit_q <= 1'b1; // R17
      is_input_q <= 1'b1;
      bit_q <= rmt_in[rmt_in_off[3:0]];
    end else if (ref_num >= `IOFS_REF_FP_OUT_FIRST &&
                 ref_num <= `IOFS_REF_FP_OUT_LAST) begin
      hit_q <= 1'b1;
      is_input_q <= 1'b0;
      bit_q <= fp_out_val[fp_out_off[0]];
    end else if (ref_num >= `IOFS_REF_RMT_OUT_FIRST &&
                 ref_num <= `IOFS_REF_RMT_OUT_LAST) begin
      hit_q <= 1'b1;
      is_input_q <= 1'b0;
      bit_q <= rmt_out_val[rmt_out_off[3:0]];
    end else begin
      hit_q <= 1'b0;
      is_input_q <= 1'b0;
      bit_q <= 1'b0;
    end
  end

endmodule : iofs_point_map

/* rtl/iofs_bank.sv */
// Output fault status, output source select and event history bank
`timescale 1ns/1ps
`include "iofs_consts.svh"

// Summary of operation
// R1: Terminal 2 power fault in bit 31, terminal 1 in bit 30.
// R2: Open load on remote outputs 1 to 8 in bits 16 to 23.
// R3: Over-temperature on remote outputs 1 to 8 in bits 0 to 7.
// R4: Fault bits 24 to 29 and 8 to 15 carry no fault.
// R5: Select bit 1 lets only the position switch function drive the output.
// R6: Select bit 0 lets only host writes drive the output.
// R7: Faceplate select word: output 1 in bit 0, output 2 in bit 1.
// R8: Remote select word: outputs 1 to 12 in bits 0 to 11.
// R9: Host drives faceplate outputs via 2109, remote outputs via 2110.
// R10: Read-only history of ten newest events in ten words.
// R11: Lowest word holds the newest event, older ones follow.
// R12: History includes events restored from non-volatile storage.
// R13: Parameter instructions refuse digital I/O reference points.
// R14: Faceplate high-speed inputs 1 and 2 read at 3000 and 3001.
// R15: Faceplate inputs 3 to 8 read at 3002 to 3007.
// R16: Faceplate inputs 3,4 share points with outputs 1,2 per configuration.
// R17: Remote inputs 1 to 16 read at 3032 to 3047.
// R18: Word 2109 holds faceplate outputs 1,2 in bits 0,1.
// R19: Word 2110 holds remote outputs 1-12; locked bits become read-only.
// R20: Reserved fault and select bits read zero; reserved writes ignored.
// R21: Fault bits follow the current detected condition.
module iofs_bank (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Instruction port from the host processor
  input wire logic cmd_valid,
  input wire iofs_pkg::iofs_cmd_t cmd_kind,
  input wire logic [15:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  output logic cmd_ready_q,
  output logic rsp_valid_q,
  output logic rsp_err_q,
  output logic [31:0] rsp_rdata_q,
  // Fault detectors
  input wire logic [1:0] term_power_fault,
  input wire logic [`IOFS_FLT_OUTS-1:0] open_load,
  input wire logic [`IOFS_FLT_OUTS-1:0] over_temp,
  // Position switch function drive
  input wire logic [`IOFS_FP_OUTS-1:0] position_switch_fp,
  input wire logic [`IOFS_RMT_OUTS-1:0] position_switch_rmt,
  // Hardware configuration
  input wire logic [`IOFS_FP_OUTS-1:0] fp_shared_is_output,
  input wire logic [`IOFS_RMT_OUTS-1:0] rmt_out_locked,
  // Input points
  input wire logic [`IOFS_FP_INS-1:0] faceplate_input,
  input wire logic [`IOFS_RMT_INS-1:0] remote_input,
  // Event sources
  input wire logic event_valid,
  input wire logic [31:0] event_data,
  input wire logic nv_event_valid,
  input wire logic [31:0] nv_event_data,
  // Output points
  output logic [`IOFS_FP_OUTS-1:0] faceplate_output_q,
  output logic [`IOFS_FP_OUTS-1:0] faceplate_shared_oe_n_q,
  output logic [`IOFS_RMT_OUTS-1:0] remote_output_q
);
  import iofs_pkg::*;

  // Latched instruction and stored words
  iofs_state_t state_q;
  iofs_cmd_t kind_q;
  logic [15:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] fault_q;
  logic [`IOFS_FP_OUTS-1:0] fp_src_q;
  logic [`IOFS_RMT_OUTS-1:0] rmt_src_q;
  logic [`IOFS_FP_OUTS-1:0] fp_val_q;
  logic [`IOFS_RMT_OUTS-1:0] rmt_val_q;
  // Lookup results and decode helpers
  logic [31:0] hist_rd;
  logic [15:0] hist_off;
  logic pt_hit;
  logic pt_is_input;
  logic pt_bit;
  logic take;
  logic hist_push;
  logic [31:0] hist_data;
  logic [15:0] fp_out_off;
  logic [15:0] rmt_out_off;
  logic is_param_wr;
  logic is_io_wr;
  logic [31:0] rd_d;
  logic err_d;
  logic [`IOFS_RMT_OUTS-1:0] rmt_wr_mask;

  // Writes commit at the answer edge, and only when not refused
  assign take = (state_q == IOFS_ST_IDLE) && cmd_valid;
  assign is_param_wr = (state_q == IOFS_ST_BUSY) &&
                       (kind_q == IOFS_CMD_PARAM_WR) && !err_d;
  assign is_io_wr = (state_q == IOFS_ST_BUSY) &&
                    (kind_q == IOFS_CMD_IO_WR) && !err_d;
  assign hist_off = cmd_addr - `IOFS_PN_HIST_FIRST;
  assign fp_out_off = addr_q - `IOFS_REF_FP_OUT_FIRST;
  assign rmt_out_off = addr_q - `IOFS_REF_RMT_OUT_FIRST;
  // Host writes never reach outputs locked as drive enable or reset
  assign rmt_wr_mask = ~rmt_out_locked; // R19

  // Live events win; restored entries fill in while the event line is quiet
  assign hist_push = event_valid | nv_event_valid; // R12
  assign hist_data = event_valid ? event_data : nv_event_data;

  // Both lookups sample the live address at the take edge
  iofs_event_mem u_hist (
    .sys_clk(sys_clk),
    .rst(rst),
    .push(hist_push),
    .push_data(hist_data),
    .rd_index(hist_off[3:0]),
    .rd_data_q(hist_rd)
  );

  iofs_point_map u_points (
    .sys_clk(sys_clk),
    .rst(rst),
    .ref_num(cmd_addr),
    .fp_in(faceplate_input),
    .rmt_in(remote_input),
    .fp_out_val(fp_val_q),
    .rmt_out_val(rmt_val_q),
    .hit_q(pt_hit),
    .is_input_q(pt_is_input),
    .bit_q(pt_bit)
  );

  // Sequencer: take one instruction, answer it on the next edge
  // No queue: a request seen while busy simply waits for ready
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= IOFS_ST_IDLE;
    end else begin
      case (state_q)
        IOFS_ST_IDLE: begin
          if (cmd_valid) begin
            state_q <= IOFS_ST_BUSY;
          end
        end
        IOFS_ST_BUSY: begin
          state_q <= IOFS_ST_IDLE;
        end
        default: begin
          state_q <= IOFS_ST_IDLE;
        end
      endcase
    end
  end

  // Latch the instruction so the host may drop it after the take edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      kind_q <= IOFS_CMD_PARAM_RD;
      addr_q <= 16'h0000;
      wdata_q <= 32'h0000_0000;
    end else if (take) begin
      kind_q <= cmd_kind;
      addr_q <= cmd_addr;
      wdata_q <= cmd_wdata;
    end
  end

  // Fault word resampled every cycle so a read sees the present state
  // One cycle of lag is accepted; the detectors are slow level signals
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fault_q <= 32'h0000_0000;
    end else begin
      fault_q <= 32'h0000_0000; // R4 R20 R21
      fault_q[`IOFS_FLT_PWR_T2] <= term_power_fault[1]; // R1
      fault_q[`IOFS_FLT_PWR_T1] <= term_power_fault[0]; // R1
      fault_q[`IOFS_FLT_OL_LSB +: `IOFS_FLT_OUTS] <= open_load; // R2
      fault_q[`IOFS_FLT_OT_LSB +: `IOFS_FLT_OUTS] <= over_temp; // R3
    end
  end

  // Read data and refusal for the held instruction
  // History reads see the word registered at the take edge
  always_comb begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    case (kind_q)
      IOFS_CMD_PARAM_RD, IOFS_CMD_PARAM_WR: begin
        if (addr_q >= `IOFS_REF_SPAN_FIRST &&
            addr_q <= `IOFS_REF_SPAN_LAST) begin
          err_d = 1'b1; // R13
        end else if (addr_q == `IOFS_PN_RMT_FAULT) begin
          rd_d = fault_q;
          err_d = (kind_q == IOFS_CMD_PARAM_WR);
        end else if (addr_q == `IOFS_PN_FP_SRC) begin
          rd_d[`IOFS_FP_OUTS-1:0] = fp_src_q; // R7 R20
        end else if (addr_q == `IOFS_PN_RMT_SRC) begin
          rd_d[`IOFS_RMT_OUTS-1:0] = rmt_src_q; // R8 R20
        end else if (addr_q == `IOFS_PN_FP_OUT_VAL) begin
          rd_d[`IOFS_FP_OUTS-1:0] = fp_val_q; // R18
        end else if (addr_q == `IOFS_PN_RMT_OUT_VAL) begin
          rd_d[`IOFS_RMT_OUTS-1:0] = rmt_val_q; // R19
        end else if (addr_q >= `IOFS_PN_HIST_FIRST &&
                     addr_q <= `IOFS_PN_HIST_LAST) begin
          rd_d = hist_rd; // R10 R11
          err_d = (kind_q == IOFS_CMD_PARAM_WR); // R10
        end else begin
          err_d = 1'b1;
        end
      end
      IOFS_CMD_IO_RD: begin
        rd_d[0] = pt_bit;
        err_d = !pt_hit;
      end
      IOFS_CMD_IO_WR: begin
        // Input points are read-only; locked remote outputs too
        err_d = !pt_hit || pt_is_input;
        if (addr_q >= `IOFS_REF_RMT_OUT_FIRST &&
            addr_q <= `IOFS_REF_RMT_OUT_LAST &&
            rmt_out_locked[rmt_out_off[3:0]]) begin
          err_d = 1'b1; // R19
        end
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  // Source select words; only the mapped bits exist
  // Reserved bits are not stored, so they always read back as zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fp_src_q <= `IOFS_FP_OUTS'(`IOFS_SRC_RESET);
      rmt_src_q <= `IOFS_RMT_OUTS'(`IOFS_SRC_RESET);
    end else if (is_param_wr) begin
      if (addr_q == `IOFS_PN_FP_SRC) begin
        fp_src_q <= wdata_q[`IOFS_FP_OUTS-1:0]; // R7 R20
      end
      if (addr_q == `IOFS_PN_RMT_SRC) begin
        rmt_src_q <= wdata_q[`IOFS_RMT_OUTS-1:0]; // R8 R20
      end
    end
  end

  // Host output values from word writes or single-point writes
  // Locked remote bits keep their stored value on a word write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fp_val_q <= `IOFS_FP_OUTS'(`IOFS_VAL_RESET);
      rmt_val_q <= `IOFS_RMT_OUTS'(`IOFS_VAL_RESET);
    end else if (is_param_wr && addr_q == `IOFS_PN_FP_OUT_VAL) begin
      fp_val_q <= wdata_q[`IOFS_FP_OUTS-1:0]; // R9 R18
    end else if (is_param_wr && addr_q == `IOFS_PN_RMT_OUT_VAL) begin
      rmt_val_q <= (rmt_val_q & rmt_out_locked) |
                   (wdata_q[`IOFS_RMT_OUTS-1:0] & rmt_wr_mask); // R9 R19
    end else if (is_io_wr && addr_q <= `IOFS_REF_FP_OUT_LAST) begin
      fp_val_q[fp_out_off[0]] <= wdata_q[0]; // R6
    end else if (is_io_wr) begin
      rmt_val_q[rmt_out_off[3:0]] <= wdata_q[0]; // R6
    end
  end

  // Output drive: each bit picks its one permitted source
  // Host values stay stored under a set select and return when it clears
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      faceplate_output_q <= '0;
      remote_output_q <= '0;
    end else begin
      faceplate_output_q <= (fp_src_q & position_switch_fp) |
                            (~fp_src_q & fp_val_q); // R5 R6
      remote_output_q <= (rmt_src_q & position_switch_rmt) |
                         (~rmt_src_q & rmt_val_q); // R5 R6
    end
  end

  // Shared faceplate points drive only when configured as outputs
  // Reset leaves every shared point undriven until configured
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      faceplate_shared_oe_n_q <= '1;
    end else begin
      faceplate_shared_oe_n_q <= ~fp_shared_is_output; // R16
    end
  end

  // Handshake: ready drops while busy, answer is a one-cycle pulse
  // Refused answers carry zero data so a stale word never leaks out
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_err_q <= 1'b0;
      rsp_rdata_q <= 32'h0000_0000;
    end else begin
      cmd_ready_q <= !take;
      rsp_valid_q <= (state_q == IOFS_ST_BUSY);
      if (state_q == IOFS_ST_BUSY) begin
        rsp_err_q <= err_d;
        rsp_rdata_q <= err_d ? 32'h0000_0000 : rd_d;
      end
    end
  end

endmodule : iofs_bank

/* testbench/iofs_bank_asserts.sv */
// Checker for the instruction port of the bank
`timescale 1ns/1ps
module iofs_bank_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Instruction port
  input wire logic cmd_valid,
  input wire iofs_pkg::iofs_cmd_t cmd_kind,
  input wire logic [15:0] cmd_addr,
  input wire logic cmd_ready_q,
  input wire logic rsp_valid_q,
  input wire logic rsp_err_q,
  input wire logic [31:0] rsp_rdata_q,
  // Shared point configuration
  input wire logic [1:0] fp_shared_is_output,
  input wire logic [1:0] faceplate_shared_oe_n_q
);
  import iofs_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Request taken while idle, split by kind
  wire take = cmd_valid && cmd_ready_q;
  wire prd = take && cmd_kind == IOFS_CMD_PARAM_RD;
  wire pwr = take && cmd_kind == IOFS_CMD_PARAM_WR;
  sequence s_answer;
    !rsp_valid_q && !cmd_ready_q ##1 rsp_valid_q && cmd_ready_q;
  endsequence
  sequence s_refused;
    ##2 rsp_valid_q && rsp_err_q;
  endsequence
  chk_answer_two: assert property (take |=> s_answer)
    else $error("answer not two cycles after take");
  chk_pulse_one: assert property (rsp_valid_q |=> !rsp_valid_q)
    else $error("answer pulse longer than one cycle");
  chk_err_zero: assert property (rsp_valid_q && rsp_err_q |->
    rsp_rdata_q == 32'h0) else $error("refused answer carries data");
  chk_io_refused: assert property ((prd || pwr) && cmd_addr inside
    {[16'h0bb8:16'h0c63]} |-> s_refused) else $error("I/O ref reached");
  chk_ro_refused: assert property (pwr && (cmd_addr == 16'h0841 ||
    cmd_addr inside {[16'h09c4:16'h09cd]}) |-> s_refused)
    else $error("read-only word written");
  chk_hist_read: assert property (prd && cmd_addr inside
    {[16'h09c4:16'h09cd]} |-> ##2 rsp_valid_q && !rsp_err_q)
    else $error("history read refused");
  chk_fault_rsvd: assert property (prd && cmd_addr == 16'h0841 |->
    ##2 rsp_rdata_q[29:24] == 6'h0 && rsp_rdata_q[15:8] == 8'h0)
    else $error("reserved fault bits set");
  chk_fp_sel_rsvd: assert property (prd && cmd_addr == 16'h0842 |->
    ##2 rsp_rdata_q[31:2] == 30'h0) else $error("faceplate select high");
  chk_rm_sel_rsvd: assert property (prd && cmd_addr == 16'h0843 |->
    ##2 rsp_rdata_q[31:12] == 20'h0) else $error("remote select high");
  chk_shared_oe: assert property (faceplate_shared_oe_n_q ==
    ~$past(fp_shared_is_output)) else $error("shared point enable");
endmodule : iofs_bank_asserts

/* testbench/iofs_host_model.sv */
// Host processor model issuing parameter and I/O instructions
`timescale 1ns/1ps
module iofs_host_model (
  // Clock
  input wire logic sys_clk,
  // Request
  output logic cmd_valid,
  output iofs_pkg::iofs_cmd_t cmd_kind,
  output logic [15:0] cmd_addr,
  output logic [31:0] cmd_wdata,
  // Answer
  input wire logic cmd_ready_q,
  input wire logic rsp_valid_q,
  input wire logic rsp_err_q,
  input wire logic [31:0] rsp_rdata_q
);
  import iofs_pkg::*;
  // Idle request lines
  initial begin
    cmd_valid = 1'b0;
    cmd_kind = IOFS_CMD_PARAM_RD;
    cmd_addr = 16'h0;
    cmd_wdata = 32'h0;
  end
  // Hold the request until taken; a lost answer returns unknowns
  task automatic xfer(input iofs_cmd_t k, input logic [15:0] a,
    input logic [31:0] d, output logic e, output logic [31:0] r);
    int n;
    n = 0;
    e = 1'bx;
    r = 32'hxxxx_xxxx;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_addr = a;
    cmd_wdata = d;
    while (cmd_ready_q !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    @(negedge sys_clk);
    // Stale address and data are inverted so nothing can lean on them
    cmd_valid = 1'b0;
    cmd_addr = ~a;
    cmd_wdata = ~d;
    while (rsp_valid_q !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    if (n < 20) begin
      e = rsp_err_q;
      r = rsp_rdata_q;
    end
  endtask : xfer
endmodule : iofs_host_model

/* testbench/tb_top.sv */
// Self-checking bench of the fault, source select and event bank
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((e) !== (a)) begin \
  num_errors++; $display("wrong value %s exp %h got %h", n, e, a); end end
module tb_top;
  import iofs_pkg::*;
  localparam iofs_cmd_t PR = IOFS_CMD_PARAM_RD;
  localparam iofs_cmd_t PW = IOFS_CMD_PARAM_WR;
  localparam iofs_cmd_t IR = IOFS_CMD_IO_RD;
  localparam iofs_cmd_t IW = IOFS_CMD_IO_WR;
  logic sys_clk, rst, cmd_valid, cmd_ready_q, rsp_valid_q, rsp_err_q, e;
  logic event_valid, nv_event_valid;
  iofs_cmd_t cmd_kind;
  logic [15:0] cmd_addr, remote_input;
  logic [31:0] cmd_wdata, rsp_rdata_q, event_data, nv_event_data, r;
  logic [1:0] term_power_fault, position_switch_fp, fp_shared_is_output;
  logic [1:0] faceplate_output_q, faceplate_shared_oe_n_q;
  logic [7:0] open_load, over_temp, faceplate_input;
  logic [11:0] position_switch_rmt, rmt_out_locked, remote_output_q;
  int total_checks, num_errors;
  iofs_host_model i_host (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q),
    .rsp_err_q(rsp_err_q), .rsp_rdata_q(rsp_rdata_q));
  iofs_bank i_dut (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q),
    .rsp_err_q(rsp_err_q), .rsp_rdata_q(rsp_rdata_q),
    .term_power_fault(term_power_fault), .open_load(open_load),
    .over_temp(over_temp), .position_switch_fp(position_switch_fp),
    .position_switch_rmt(position_switch_rmt),
    .fp_shared_is_output(fp_shared_is_output),
    .rmt_out_locked(rmt_out_locked), .faceplate_input(faceplate_input),
    .remote_input(remote_input), .event_valid(event_valid),
    .event_data(event_data), .nv_event_valid(nv_event_valid),
    .nv_event_data(nv_event_data), .faceplate_output_q(faceplate_output_q),
    .faceplate_shared_oe_n_q(faceplate_shared_oe_n_q),
    .remote_output_q(remote_output_q));
  // One instruction; data is judged on reads and on refusals
  task op(input iofs_cmd_t k, input logic [15:0] a, input logic [31:0] d,
    input logic xe, input logic [31:0] x);
    i_host.xfer(k, a, d, e, r);
    `CHK("refused", xe, e)
    if (xe || !k[0]) `CHK("rdata", x, r)
  endtask : op
  // Outputs lag the stored value by a cycle
  task outs(input logic [1:0] f, input logic [11:0] m);
    repeat (2) @(negedge sys_clk);
    `CHK("faceplate out", f, faceplate_output_q)
    `CHK("remote out", m, remote_output_q)
  endtask : outs
  task push(input logic nv, input logic [31:0] d);
    @(negedge sys_clk);
    event_valid = !nv;
    nv_event_valid = nv;
    event_data = d;
    nv_event_data = d;
    @(negedge sys_clk);
    event_valid = 1'b0;
    nv_event_valid = 1'b0;
  endtask : push
  task t_reset;
    op(PR, 16'h0842, 32'h0, 1'b0, 32'h0);
    op(PR, 16'h0843, 32'h0, 1'b0, 32'h0);
    op(PR, 16'h09c4, 32'h0, 1'b0, 32'h0);
    `CHK("shared oe", 2'b11, faceplate_shared_oe_n_q)
    outs(2'b00, 12'h000);
  endtask : t_reset
  task t_fault;
    term_power_fault = 2'b10;
    open_load = 8'h81;
    over_temp = 8'h03;
    op(PR, 16'h0841, 32'h0, 1'b0, 32'h8081_0003);
    term_power_fault = 2'b01;
    open_load = 8'h18;
    over_temp = 8'h40;
    op(PR, 16'h0841, 32'h0, 1'b0, 32'h4018_0040);
    term_power_fault = 2'b11;
    open_load = 8'hff;
    over_temp = 8'hff;
    op(PR, 16'h0841, 32'h0, 1'b0, 32'hc0ff_00ff);
    op(PW, 16'h0841, 32'hffff_ffff, 1'b1, 32'h0);
  endtask : t_fault
  task t_select;
    op(PW, 16'h0842, 32'hffff_ffff, 1'b0, 32'h0);
    op(PR, 16'h0842, 32'h0, 1'b0, 32'h3);
    op(PW, 16'h0843, 32'hffff_ffff, 1'b0, 32'h0);
    op(PR, 16'h0843, 32'h0, 1'b0, 32'hfff);
    position_switch_fp = 2'b10;
    position_switch_rmt = 12'h5a5;
    op(PW, 16'h083d, 32'h1, 1'b0, 32'h0);
    outs(2'b10, 12'h5a5);
    op(PW, 16'h0842, 32'h0, 1'b0, 32'h0);
    op(PW, 16'h0843, 32'h0, 1'b0, 32'h0);
    outs(2'b01, 12'h000);
    op(PW, 16'h083e, 32'hffff_fabc, 1'b0, 32'h0);
    outs(2'b01, 12'habc);
    op(PR, 16'h083e, 32'h0, 1'b0, 32'habc);
    op(PR, 16'h083d, 32'h0, 1'b0, 32'h1);
    // Lock output 3, which holds a one, so a kept bit is visible
    rmt_out_locked = 12'h004;
    op(PW, 16'h083e, 32'h0, 1'b0, 32'h0);
    op(PR, 16'h083e, 32'h0, 1'b0, 32'h4);
    op(IW, 16'h0c5a, 32'h0, 1'b1, 32'h0);
    op(IW, 16'h0c59, 32'h1, 1'b0, 32'h0);
    op(PR, 16'h083e, 32'h0, 1'b0, 32'h6);
  endtask : t_select
  task t_io;
    faceplate_input = 8'ha5;
    remote_input = 16'h1234;
    fp_shared_is_output = 2'b01;
    for (int i = 0; i < 8; i++)
      op(IR, 16'h0bb8 + 16'(i), 0, 1'b0, 32'(faceplate_input[i]));
    for (int i = 0; i < 16; i++)
      op(IR, 16'(16'h0bd8 + i), 0, 1'b0, {31'h0, remote_input[i]});
    op(PR, 16'h0bb8, 32'h0, 1'b1, 32'h0);
    op(PW, 16'h0bd8, 32'h1, 1'b1, 32'h0);
    op(IW, 16'h0bb8, 32'h1, 1'b1, 32'h0);
    op(PR, 16'h0001, 32'h0, 1'b1, 32'h0);
    `CHK("shared oe", 2'b10, faceplate_shared_oe_n_q)
    op(IW, 16'h0c39, 32'h1, 1'b0, 32'h0);
    outs(2'b11, 12'h006);
  endtask : t_io
  task t_hist;
    push(1'b1, 32'h100);
    push(1'b1, 32'h101);
    for (int i = 0; i < 9; i++)
      push(1'b0, 32'(32'h200 + i));
    for (int i = 0; i < 9; i++)
      op(PR, 16'h09c4 + 16'(i), 0, 1'b0, 32'h208 - 32'(i));
    op(PR, 16'h09cd, 32'h0, 1'b0, 32'h101);
    op(PW, 16'h09c4, 32'h1, 1'b1, 32'h0);
    op(PR, 16'h09c4, 32'h0, 1'b0, 32'h208);
  endtask : t_hist
  task final_report;
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Watchdog well past the few hundred cycles the run needs
  initial begin
    #100us;
    num_errors++;
    final_report();
  end
  initial begin
    {rst, event_valid, nv_event_valid} = 3'b100;
    {event_data, nv_event_data} = 64'h0;
    {term_power_fault, open_load, over_temp} = 18'h0;
    {position_switch_fp, position_switch_rmt} = 14'h0;
    {fp_shared_is_output, rmt_out_locked} = 14'h0;
    {faceplate_input, remote_input} = 24'h0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_fault();
    t_select();
    t_io();
    t_hist();
    final_report();
  end
endmodule : tb_top
bind iofs_bank iofs_bank_asserts i_chk (.sys_clk(sys_clk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
  .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q),
  .rsp_err_q(rsp_err_q), .rsp_rdata_q(rsp_rdata_q),
  .fp_shared_is_output(fp_shared_is_output),
  .faceplate_shared_oe_n_q(faceplate_shared_oe_n_q));
